// ===== src/rcr_regbank.sv
// Regulator command register bank top
// Functional notes
// - Warning flag bit 2 on limit exceed
// - Fault flag bit 1 on limit exceed
// - Voltage readback returns two-byte code
// - Current readback returns two bytes, amperes
// - Max load readback returns strapped value
// - Soft reset restores defaults unless locked
// - Lock bit freezes lockable limit registers
// - Lock persists until srst; soft reset does not clear it
// - Ramp field loads strap each startup
// - Ramp codes decode doubling from 0.125
`timescale 1ns/10ps
`include "rcr_consts.svh"
module rcr_regbank
	import rcr_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      srst,
	// Startup and straps
	input  wire logic      startupPulse,
	input  wire rcr_ramp_t softStartStrap,
	// Measurements
	input  wire rcr_meas_s meas,
	// Command port
	input  wire rcr_req_s  req,
	output rcr_rsp_s       rsp,
	// Regulator control outputs
	output logic [7:0]     rampRateEighths,
	output logic           lockActive
);
	logic [7:0]  statusFf,    nxt_status;
	logic        lockFf,      nxt_lock;
	logic [2:0]  rampFf,      nxt_ramp;
	logic [7:0]  warnLimFf,   nxt_warnLim;
	logic [7:0]  faultLimFf,  nxt_faultLim;
	logic [15:0] voutFf,      nxt_vout;
	logic [15:0] ioutFf,      nxt_iout;
	logic [15:0] maxLoadFf,   nxt_maxLoad;
	rcr_rsp_s    rspFf,       nxt_rsp;
	logic [7:0]  rateFf,      nxt_rate;
	logic [7:0]  rateDec;
	logic        overWarn;
	logic        overFault;
	logic        softReset;

	rcr_mon_compare u_cmp (
		.monitoredVoltage (meas.monVoltage),
		.warnLimit        (warnLimFf),
		.faultLimit       (faultLimFf),
		.overWarn         (overWarn),
		.overFault        (overFault)
	);

	rcr_ramp_decode u_dec (
		.code        (rampFf),
		.rateEighths (rateDec)
	);

	// Register state update
	always_comb begin
		softReset    = req.wrEn && req.cmd == `RCR_OFS_LOCK_RESET
			&& req.wrData[`RCR_BIT_SOFT_RESET] && !lockFf;
		nxt_status   = statusFf;
		nxt_lock     = lockFf;
		nxt_ramp     = rampFf;
		nxt_warnLim  = warnLimFf;
		nxt_faultLim = faultLimFf;
		nxt_vout     = meas.voutCode;
		nxt_iout     = meas.ioutAmps;
		nxt_maxLoad  = meas.maxLoadAmps;
		nxt_rate     = rateDec;
		if (softReset) begin
			nxt_status   = `RCR_RST_BYTE;
			nxt_ramp     = softStartStrap;
			nxt_warnLim  = `RCR_WARN_LIMIT_RST;
			nxt_faultLim = `RCR_FAULT_LIMIT_RST;
		end else if (req.wrEn) begin
			case (req.cmd)
				`RCR_OFS_LOCK_RESET: begin
					if (req.wrData[`RCR_BIT_LOCK]) begin
						nxt_lock = 1'b1;
					end
				end
				`RCR_OFS_RAMP_RATE: begin
					nxt_ramp = req.wrData[`RCR_RAMP_MSB:`RCR_RAMP_LSB];
				end
				`RCR_OFS_WARN_LIMIT: begin
					if (!lockFf) begin
						nxt_warnLim = req.wrData;
					end
				end
				`RCR_OFS_FAULT_LIMIT: begin
					if (!lockFf) begin
						nxt_faultLim = req.wrData;
					end
				end
				default: begin
					nxt_lock = lockFf;
				end
			endcase
		end
		if (startupPulse) begin
			nxt_ramp = softStartStrap;
		end
		// Sticky flags, set wins over clear
		if (overWarn) begin
			nxt_status[`RCR_BIT_MON_WARN] = 1'b1;
		end
		if (overFault) begin
			nxt_status[`RCR_BIT_MON_FAULT] = 1'b1;
		end
		nxt_rsp         = '0;
		nxt_rsp.valid   = req.rdEn;
		case (req.cmd)
			`RCR_OFS_ALERT_STATUS:  nxt_rsp.data = {8'h00, statusFf};
			`RCR_OFS_VOUT_READBACK: begin
				nxt_rsp.data    = voutFf;
				nxt_rsp.twoByte = 1'b1;
			end
			`RCR_OFS_IOUT_READBACK: begin
				nxt_rsp.data    = ioutFf;
				nxt_rsp.twoByte = 1'b1;
			end
			`RCR_OFS_MAKER_CODE:    nxt_rsp.data = {8'h00, `RCR_MAKER_VAL};
			`RCR_OFS_MODEL_CODE: begin
				nxt_rsp.data    = `RCR_MODEL_VAL;
				nxt_rsp.twoByte = 1'b1;
			end
			`RCR_OFS_REVISION_CODE: nxt_rsp.data = {8'h00, `RCR_REVISION_VAL};
			`RCR_OFS_LOCK_RESET:    nxt_rsp.data = {15'h0000, lockFf};
			`RCR_OFS_RAMP_RATE:     nxt_rsp.data = {8'h00, rampFf, 5'h00};
			`RCR_OFS_MAX_LOAD: begin
				nxt_rsp.data    = maxLoadFf;
				nxt_rsp.twoByte = 1'b1;
			end
			`RCR_OFS_WARN_LIMIT:    nxt_rsp.data = {8'h00, warnLimFf};
			`RCR_OFS_FAULT_LIMIT:   nxt_rsp.data = {8'h00, faultLimFf};
			default:                nxt_rsp.data = `RCR_RST_WORD;
		endcase
		if (!req.rdEn) begin
			nxt_rsp = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			statusFf   <= `RCR_RST_BYTE;
			lockFf     <= 1'b0;
			rampFf     <= 3'h0;
			warnLimFf  <= `RCR_WARN_LIMIT_RST;
			faultLimFf <= `RCR_FAULT_LIMIT_RST;
			voutFf     <= `RCR_RST_WORD;
			ioutFf     <= `RCR_RST_WORD;
			maxLoadFf  <= `RCR_RST_WORD;
			rspFf      <= '0;
			rateFf     <= 8'h01;
		end else begin
			statusFf   <= nxt_status;
			lockFf     <= nxt_lock;
			rampFf     <= nxt_ramp;
			warnLimFf  <= nxt_warnLim;
			faultLimFf <= nxt_faultLim;
			voutFf     <= nxt_vout;
			ioutFf     <= nxt_iout;
			maxLoadFf  <= nxt_maxLoad;
			rspFf      <= nxt_rsp;
			rateFf     <= nxt_rate;
		end
	end

	always_comb begin
		rsp             = rspFf;
		rampRateEighths = rateFf;
		lockActive      = lockFf;
	end
endmodule : rcr_regbank

// ===== pkg/rcr_consts.svh
// Register map constants for the regulator command register bank
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH
`define RCR_OFS_ALERT_STATUS   8'h80
`define RCR_OFS_VOUT_READBACK  8'h8b
`define RCR_OFS_IOUT_READBACK  8'h8c
`define RCR_OFS_MAKER_CODE     8'h99
`define RCR_OFS_MODEL_CODE     8'h9a
`define RCR_OFS_REVISION_CODE  8'h9b
`define RCR_OFS_LOCK_RESET     8'hd0
`define RCR_OFS_RAMP_RATE      8'hd6
`define RCR_OFS_MAX_LOAD       8'hdd
`define RCR_OFS_WARN_LIMIT     8'he0
`define RCR_OFS_FAULT_LIMIT    8'he1
`define RCR_BIT_MON_WARN       2
`define RCR_BIT_MON_FAULT      1
`define RCR_BIT_SOFT_RESET     1
`define RCR_BIT_LOCK           0
`define RCR_RAMP_MSB           7
`define RCR_RAMP_LSB           5
`define RCR_RST_BYTE           8'h00
`define RCR_RST_WORD           16'h0000
`define RCR_WARN_LIMIT_RST     8'hc0
`define RCR_FAULT_LIMIT_RST    8'he0
`define RCR_MAKER_VAL          8'h5a
`define RCR_MODEL_VAL          16'h0abc
`define RCR_REVISION_VAL       8'h01
`endif

// ===== pkg/rcr_pkg.sv
// Types for the regulator command register bank
package rcr_pkg;
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] cmd;
		logic [7:0] wrData;
	} rcr_req_s;
	typedef struct packed {
		logic        valid;
		logic        twoByte;
		logic [15:0] data;
	} rcr_rsp_s;
	typedef struct packed {
		logic [15:0] voutCode;
		logic [15:0] ioutAmps;
		logic [15:0] maxLoadAmps;
		logic [7:0]  monVoltage;
	} rcr_meas_s;
	typedef logic [2:0] rcr_ramp_t;
endpackage : rcr_pkg

// ===== src/rcr_ramp_decode.sv
// Ramp code to slew rate decoder, in units of 0.125 mV/us
`timescale 1ns/10ps
`include "rcr_consts.svh"
module rcr_ramp_decode
	import rcr_pkg::*;
(
	// Code in
	input  wire rcr_ramp_t   code,
	// Rate out
	output logic [7:0]       rateEighths
);
	always_comb begin
		rateEighths = 8'h01 << code;
	end
endmodule : rcr_ramp_decode

// ===== src/rcr_mon_compare.sv
// Monitored voltage limit comparator
`timescale 1ns/10ps
module rcr_mon_compare (
	// Inputs
	input  wire logic [7:0] monitoredVoltage,
	input  wire logic [7:0] warnLimit,
	input  wire logic [7:0] faultLimit,
	// Outputs
	output logic            overWarn,
	output logic            overFault
);
	always_comb begin
		overWarn  = monitoredVoltage > warnLimit;
		overFault = monitoredVoltage > faultLimit;
	end
endmodule : rcr_mon_compare

// ===== tb/rcr_host_model.sv
// Host side command model
`timescale 1ns/10ps
module rcr_host_model
	import rcr_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Command out
	output rcr_req_s  req
);
	initial req = '0;
	// One strobe cycle, then idle; result settled 1 ns after taking edge
	task xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
		@(posedge clk) req <= '{w, !w, c, d};
		@(posedge clk) req <= '0;
		#1;
	endtask : xfer
endmodule : rcr_host_model

// ===== tb/rcr_regbank_asserts.sv
// Port checker for the register bank
`timescale 1ns/10ps
module rcr_regbank_asserts
	import rcr_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// Inputs
	input wire logic       startupPulse,
	input wire rcr_ramp_t  softStartStrap,
	input wire rcr_meas_s  meas,
	input wire rcr_req_s   req,
	// Outputs
	input wire rcr_rsp_s   rsp,
	input wire logic [7:0] rampRateEighths,
	input wire logic       lockActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_rd_answer: assert property (req.rdEn |=> rsp.valid)
		else $error("no answer");
	a_vout_read: assert property (req.rdEn && req.cmd == 8'h8b |=>
		rsp.twoByte && rsp.data == $past(meas.voutCode, 2)) else $error("vout");
	a_iout_read: assert property (req.rdEn && req.cmd == 8'h8c |=>
		rsp.twoByte && rsp.data == $past(meas.ioutAmps, 2)) else $error("iout");
	a_max_current_strap_pin_read: assert property (req.rdEn && req.cmd == 8'hdd |=>
		rsp.twoByte && rsp.data == $past(meas.maxLoadAmps, 2)) else $error("max_current_strap_pin");
	a_lock_set: assert property (req.wrEn && req.cmd == 8'hd0 &&
		req.wrData[1:0] == 2'b01 |=> lockActive) else $error("lock set");
	a_lock_keep: assert property (lockActive |=> lockActive)
		else $error("lock lost");
	a_ramp_load: assert property (startupPulse |=> ##1
		rampRateEighths == 8'h01 << $past(softStartStrap, 2)) else $error("ramp");
	a_status_rsv: assert property (req.rdEn && req.cmd == 8'h80 |=>
		(rsp.data & 16'hfff9) == 16'h0000) else $error("reserved");
	c_lock: cover property (lockActive);
	c_start: cover property (startupPulse);
	c_flag: cover property (req.rdEn && req.cmd == 8'h80 ##1 rsp.data[2]);
endmodule : rcr_regbank_asserts
bind rcr_regbank rcr_regbank_asserts i_chk (.clk(clk), .srst(srst),
	.startupPulse(startupPulse), .softStartStrap(softStartStrap), .meas(meas),
	.req(req), .rsp(rsp), .rampRateEighths(rampRateEighths), .lockActive(lockActive));

// ===== tb/rcr_regbank_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
`include "rcr_consts.svh"
module rcr_regbank_tb_top
	import rcr_pkg::*;
;
	logic        clk;
	logic        srst;
	logic        startupPulse;
	rcr_ramp_t   softStartStrap;
	rcr_meas_s   meas;
	rcr_req_s    req;
	rcr_rsp_s    rsp;
	logic [7:0]  rampRateEighths;
	logic        lockActive;
	int          errors;
	int          comparisons;
	logic [24:0] rows [12] = '{{8'h8b, 17'h11234}, {8'h8c, 17'h10042}, {8'hdd, 17'h10050},
		{8'h99, 9'h0, `RCR_MAKER_VAL}, {8'h9a, 1'b1, `RCR_MODEL_VAL},
		{8'h9b, 9'h0, `RCR_REVISION_VAL}, {8'h80, 17'h0}, {8'hd0, 17'h0},
		{8'hd6, 17'h0}, {8'he0, 17'hc0}, {8'he1, 17'he0}, {8'h55, 17'h0}};
	rcr_host_model i_host (.clk(clk), .req(req));
	rcr_regbank i_dut (.clk(clk), .srst(srst), .startupPulse(startupPulse),
		.softStartStrap(softStartStrap), .meas(meas), .req(req), .rsp(rsp),
		.rampRateEighths(rampRateEighths), .lockActive(lockActive));
	task chk(input logic [17:0] g, input logic [17:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task rd(input logic [7:0] c, input logic [16:0] e);
		i_host.xfer(1'b0, c, 8'h00);
		chk({rsp.valid, rsp.twoByte, rsp.data}, {1'b1, e});
	endtask : rd
	task end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		errors++;
		end_sim;
	end
	initial begin
		srst = 1'b1;
		startupPulse = 1'b0;
		softStartStrap = 3'h0;
		meas = '{16'h1234, 16'h0042, 16'h0050, 8'h00};
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) rd(rows[i][24:17], rows[i][16:0]);
		for (int k = 0; k < 8; k++) begin
			i_host.xfer(1'b1, 8'hd6, {k[2:0], 5'h1f});
			rd(8'hd6, {9'h0, k[2:0], 5'h0});
			chk(rampRateEighths, 8'h01 << k);
		end
		@(posedge clk) begin
			softStartStrap <= 3'h3;
			startupPulse <= 1'b1;
		end
		@(posedge clk) startupPulse <= 1'b0;
		rd(8'hd6, 17'h60);
		@(posedge clk) meas.monVoltage <= 8'hd0;
		repeat (2) @(posedge clk);
		rd(8'h80, 17'h4);
		@(posedge clk) meas.monVoltage <= 8'hf0;
		repeat (2) @(posedge clk);
		rd(8'h80, 17'h6);
		@(posedge clk) meas.monVoltage <= 8'h00;
		i_host.xfer(1'b1, 8'hd6, 8'h00);
		i_host.xfer(1'b1, 8'hd0, 8'h02);
		rd(8'h80, 17'h0);
		i_host.xfer(1'b1, 8'h80, 8'hff);
		rd(8'h80, 17'h0);
		rd(8'hd6, 17'h60);
		i_host.xfer(1'b1, 8'he0, 8'h10);
		i_host.xfer(1'b1, 8'hd0, 8'h01);
		i_host.xfer(1'b1, 8'he0, 8'h20);
		rd(8'he0, 17'h10);
		i_host.xfer(1'b1, 8'hd0, 8'h02);
		rd(8'he0, 17'h10);
		rd(8'hd0, 17'h1);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		rd(8'hd0, 17'h0);
		rd(8'he0, 17'hc0);
		end_sim;
	end
endmodule : rcr_regbank_tb_top
